// ---- hw/asm_alert.sv ----
// Contract
// - group two bit layout for faults
// - bit 5 fan four or timer limit
// - flags sticky until gone and read
// - alert held while out of limit
// - mask gates alert, not the flag
// - first mask register bit layout
// - second mask register bit layout
// - mask bit 5 follows bit 5 source
// - alert pins disabled after reset
// - config four bit 0 selects supply pin
// - config three bit 0 selects pin
// - config three bit 1 enables overheat line
// - flag overheat line held time for timing
// - full_speed_on_overheat runs fans full while held
// - full_speed_on_overheat only for running fans
// - group one bit 7 summarises group two
// - timer over limit sets bit 5 when config three bit 1 is set
`timescale 1ns/1ps
`default_nettype none
`include "asm_params.svh"

module asm_alert (
  // clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_srst,
  // register port from the serial interface
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [7:0] i_reg_wdata,
  output      logic [7:0] o_reg_rdata,
  // limit comparator levels
  input  wire logic [7:0] i_grp1_cond,
  input  wire logic       i_diode_two_fault,
  input  wire logic       i_diode_one_fault,
  input  wire logic       i_cooler_four_slow,
  input  wire logic       i_cooler_three_slow,
  input  wire logic       i_cooler_two_slow,
  input  wire logic       i_cooler_one_slow,
  input  wire logic       i_critical_temp,
  input  wire logic       i_hot_timer_over,
  // overheat line pin, active low
  input  wire logic       i_overheat_line,
  input  wire logic       i_overheat_drive_req,
  output      logic       o_overheat_line,
  output      logic       o_overheat_line_oe,
  output      logic       o_overheat_timing,
  // fan drive
  input  wire logic [2:0] i_fan_running,
  output      logic [2:0] o_full_speed,
  // alert outputs, the two pin outputs open drain
  output      logic       o_alert_n,
  output      logic       o_supply_pin_alert_o,
  output      logic       o_supply_pin_alert_oe,
  output      logic       o_mp_pin_alert_o,
  output      logic       o_mp_pin_alert_oe
);

  asm_pkg::asm_state_t state_r;
  asm_pkg::asm_state_t state_nxt;

  logic [7:0] cond1_v;
  logic [7:0] cond2_v;
  logic       line_en;
  logic       full_speed_on_overheat_en;
  logic       ext_hold;
  logic       rd_st1;
  logic       rd_st2;

  // sticky update: a new event wins over a clear by read
  function automatic logic [7:0] sticky(input logic [7:0] cur,
                                        input logic [7:0] cond,
                                        input logic       clr);
    sticky = (cur & ~({8{clr}} & ~cond)) | cond;
  endfunction : sticky

  // pending alert sources from status and masks
  function automatic logic pending(input logic [7:0] s1,
                                   input logic [7:0] s2,
                                   input logic [7:0] m1,
                                   input logic [7:0] m2);
    logic p1;
    logic p2;
    p1 = |(s1 & ~m1 & `ASM_G1_VALID);
    p2 = |(s2 & ~m2 & `ASM_G2_VALID) & ~m1[`ASM_BIT_G2_SUM];
    pending = p1 | p2;
  endfunction : pending

  // condition vectors and read strobes
  always_comb
  begin
    line_en = state_r.cfg3[`ASM_BIT_LINE_EN];
    full_speed_on_overheat_en = state_r.cfg3[`ASM_BIT_FULL_SPEED_ON_OVERHEAT];
    cond1_v = i_grp1_cond & `ASM_G1_VALID;
    cond2_v = {i_diode_two_fault,
               i_diode_one_fault,
               line_en ? i_hot_timer_over : i_cooler_four_slow,
               i_cooler_three_slow,
               i_cooler_two_slow,
               i_cooler_one_slow,
               i_critical_temp,
               1'b0};
    rd_st1   = i_reg_rd && (i_reg_addr == `ASM_OFS_STATUS1);
    rd_st2   = i_reg_rd && (i_reg_addr == `ASM_OFS_STATUS2);
    ext_hold = line_en && !i_overheat_line && !i_overheat_drive_req;
  end

  // next state
  always_comb
  begin
    state_nxt = state_r;
    // sticky flags; masked sources still set their flag
    state_nxt.st1 = sticky(state_r.st1, cond1_v, rd_st1) &
                    `ASM_G1_VALID;
    state_nxt.st2 = sticky(state_r.st2, cond2_v, rd_st2) &
                    `ASM_G2_VALID;
    // register writes
    if (i_reg_wr)
    begin
      unique case (i_reg_addr)
        `ASM_OFS_MASK1: state_nxt.mask1 = i_reg_wdata;
        `ASM_OFS_MASK2: state_nxt.mask2 = i_reg_wdata;
        `ASM_OFS_CFG3:  state_nxt.cfg3  = i_reg_wdata;
        `ASM_OFS_CFG4:  state_nxt.cfg4  = i_reg_wdata;
        default: ;
      endcase
    end
    // read data shows the value before any clear
    if (i_reg_rd)
    begin
      unique case (i_reg_addr)
        `ASM_OFS_STATUS1: state_nxt.rdata = {|state_r.st2,
                                             state_r.st1[6:0]};
        `ASM_OFS_STATUS2: state_nxt.rdata = state_r.st2;
        `ASM_OFS_MASK1:   state_nxt.rdata = state_r.mask1;
        `ASM_OFS_MASK2:   state_nxt.rdata = state_r.mask2;
        `ASM_OFS_CFG3:    state_nxt.rdata = state_r.cfg3;
        `ASM_OFS_CFG4:    state_nxt.rdata = state_r.cfg4;
        default:          state_nxt.rdata = 8'h00;
      endcase
    end
    // alert tracks the new flags and masks
    state_nxt.alert = pending(state_nxt.st1, state_nxt.st2,
                              state_nxt.mask1, state_nxt.mask2);
    // overheat line held by the outside party
    state_nxt.timing = ext_hold;
    state_nxt.full_speed_on_overheat  = (ext_hold && full_speed_on_overheat_en) ?
                       i_fan_running : 3'h0;
    if (i_srst)
    begin
      state_nxt.st1    = `ASM_RST_REG;
      state_nxt.st2    = `ASM_RST_REG;
      state_nxt.mask1  = `ASM_RST_REG;
      state_nxt.mask2  = `ASM_RST_REG;
      state_nxt.cfg3   = `ASM_RST_REG;
      state_nxt.cfg4   = `ASM_RST_REG;
      state_nxt.rdata  = `ASM_RST_REG;
      state_nxt.alert  = 1'b0;
      state_nxt.timing = 1'b0;
      state_nxt.full_speed_on_overheat  = `ASM_RST_FAN;
    end
  end

  // state register
  always_ff @(posedge i_clk_sys)
  begin
    state_r <= state_nxt;
  end

  // outputs; alert pins only pull low once selected
  always_comb
  begin
    o_reg_rdata           = state_r.rdata;
    o_alert_n             = ~state_r.alert;
    o_supply_pin_alert_o  = 1'b0;
    o_supply_pin_alert_oe = state_r.cfg4[`ASM_BIT_ALERT_SEL] &&
                            state_r.alert;
    o_mp_pin_alert_o      = 1'b0;
    o_mp_pin_alert_oe     = state_r.cfg3[`ASM_BIT_ALERT_SEL] &&
                            state_r.alert;
    o_overheat_line       = 1'b0;
    o_overheat_line_oe    = line_en && i_overheat_drive_req;
    o_overheat_timing     = state_r.timing;
    o_full_speed          = state_r.full_speed_on_overheat;
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  // checks
  flag_set_a: assert property (
    (cond2_v != 8'h00) |=> ((state_r.st2 & $past(cond2_v)) ==
                            $past(cond2_v)))
    else $error("status flag not set on condition");

  flag_hold_a: assert property (
    (!rd_st2 && state_r.st2[7]) |=> state_r.st2[7])
    else $error("sticky flag lost without read");

  read_clear_a: assert property (
    rd_st2 |=> (state_r.st2 == $past(cond2_v)))
    else $error("read did not clear gone flags");

  alert_follow_a: assert property (
    state_r.alert == pending(state_r.st1, state_r.st2,
                             state_r.mask1, state_r.mask2))
    else $error("alert does not match pending flags");

  alert_raise_a: assert property (
    ((cond1_v & ~state_r.mask1) != 8'h00 && !i_reg_wr) |=> !o_alert_n)
    else $error("alert not asserted for unmasked source");

  group_mask_a: assert property (
    (state_r.mask1[7] && (state_r.st1 & ~state_r.mask1) == 8'h00)
      |-> o_alert_n)
    else $error("masked group two still alerts");

  f4_mask_a: assert property (
    (state_r.st2 == 8'h20 && state_r.mask2[5] &&
     state_r.st1 == 8'h00) |-> o_alert_n)
    else $error("bit 5 mask ignored");

  timer_flag_a: assert property (
    (line_en && i_hot_timer_over) |=> state_r.st2[`ASM_BIT_F4])
    else $error("timer limit did not set bit 5");

  summary_a: assert property (
    rd_st1 |=> (o_reg_rdata[7] == ($past(state_r.st2) != 8'h00)))
    else $error("summary bit wrong");

  pin_off_a: assert property (
    $past(i_srst) |-> (!o_supply_pin_alert_oe && !o_mp_pin_alert_oe))
    else $error("alert pin active after reset");

  pin_sel_a: assert property (
    (o_supply_pin_alert_oe |-> state_r.cfg4[0]) and
    (o_mp_pin_alert_oe |-> state_r.cfg3[0]))
    else $error("alert pin driven while unselected");

  full_speed_on_overheat_a: assert property (
    1'b1 |=> (o_full_speed == (($past(ext_hold) && $past(full_speed_on_overheat_en)) ?
                               $past(i_fan_running) : 3'h0)))
    else $error("fan full_speed_on_overheat mismatch");

  timing_a: assert property (
    ext_hold |=> o_overheat_timing)
    else $error("overheat hold not flagged");

  timing_off_a: assert property (
    !ext_hold |=> !o_overheat_timing)
    else $error("overheat timing flag without hold");

  // group one flags behave like group two
  st1_set_a: assert property (
    (cond1_v != 8'h00) |=> ((state_r.st1 & $past(cond1_v)) ==
                            $past(cond1_v)))
    else $error("group one flag not set on condition");

  st1_hold_a: assert property (
    !rd_st1 |=> ((state_r.st1 & $past(state_r.st1)) ==
                 $past(state_r.st1)))
    else $error("group one flag lost without read");

  st1_clear_a: assert property (
    rd_st1 |=> (state_r.st1 == $past(cond1_v)))
    else $error("group one read did not clear gone flags");

  st2_hold_a: assert property (
    !rd_st2 |=> ((state_r.st2 & $past(state_r.st2)) ==
                 $past(state_r.st2)))
    else $error("group two flag lost without read");

  st2_read_a: assert property (
    rd_st2 |=> (o_reg_rdata == $past(state_r.st2)))
    else $error("group two read data wrong");

  read_only_a: assert property (
    (i_reg_wr && !i_reg_rd && i_reg_addr == `ASM_OFS_STATUS2 &&
     cond2_v == 8'h00) |=> (state_r.st2 == $past(state_r.st2)))
    else $error("write changed group two flags");

  st2_unused_a: assert property (
    !state_r.st2[0])
    else $error("unused group two bit set");

  f4_slow_a: assert property (
    (!line_en && i_cooler_four_slow) |=> state_r.st2[`ASM_BIT_F4])
    else $error("fan four slow did not set bit 5");

  // alert level against the masks
  g2_raise_a: assert property (
    ((cond2_v & ~state_r.mask2) != 8'h00 && !state_r.mask1[`ASM_BIT_G2_SUM]
     && !i_reg_wr) |=> !o_alert_n)
    else $error("alert not asserted for group two source");

  mask_one_a: assert property (
    ((cond1_v & state_r.mask1) == cond1_v && state_r.st1 == 8'h00 &&
     state_r.st2 == 8'h00 && !i_reg_wr && cond2_v == 8'h00) |=> o_alert_n)
    else $error("masked group one source raised alert");

  mask_two_a: assert property (
    ((cond2_v & state_r.mask2) == cond2_v && state_r.st1 == 8'h00 &&
     state_r.st2 == 8'h00 && !i_reg_wr && cond1_v == 8'h00) |=> o_alert_n)
    else $error("masked group two source raised alert");

  pin_release_a: assert property (
    !state_r.alert |-> (!o_supply_pin_alert_oe && !o_mp_pin_alert_oe))
    else $error("alert pin driven with no pending flag");

  pin_level_a: assert property (
    !o_supply_pin_alert_o && !o_mp_pin_alert_o)
    else $error("alert pin would drive high");

  // register writes and the overheat line
  mask_write_a: assert property (
    (i_reg_wr && i_reg_addr == `ASM_OFS_MASK2) |=>
      (state_r.mask2 == $past(i_reg_wdata)))
    else $error("mask two write lost");

  cfg_write_a: assert property (
    (i_reg_wr && i_reg_addr == `ASM_OFS_CFG3) |=>
      (state_r.cfg3 == $past(i_reg_wdata)))
    else $error("config three write lost");

  line_oe_a: assert property (
    o_overheat_line_oe |-> (line_en && !o_overheat_line))
    else $error("overheat line driven while disabled");

  full_speed_on_overheat_idle_a: assert property (
    (o_full_speed & ~$past(i_fan_running)) == 3'h0)
    else $error("full_speed_on_overheat on a stopped fan");

  // main scenarios
  alert_seen_c: cover property (!o_alert_n ##[1:20] o_alert_n);
  read_clr_c:   cover property (rd_st2 && state_r.st2 != 8'h00);
  full_speed_on_overheat_c:      cover property (o_full_speed != 3'h0);
  mp_pin_c:     cover property (o_mp_pin_alert_oe);
  f4_mask_c:    cover property (state_r.st2[`ASM_BIT_F4] &&
                                state_r.mask2[`ASM_BIT_F4]);

endmodule : asm_alert

`default_nettype wire

// ---- hw/asm_params.svh ----
`ifndef ASM_PARAMS_SVH
`define ASM_PARAMS_SVH

// register offsets on the serial register port
`define ASM_OFS_STATUS1 8'h41
`define ASM_OFS_STATUS2 8'h42
`define ASM_OFS_MASK1   8'h74
`define ASM_OFS_MASK2   8'h75
`define ASM_OFS_CFG3    8'h78
`define ASM_OFS_CFG4    8'h7d

// field positions
`define ASM_BIT_ALERT_SEL 0
`define ASM_BIT_LINE_EN   1
`define ASM_BIT_FULL_SPEED_ON_OVERHEAT     2
`define ASM_BIT_G2_SUM    7
`define ASM_BIT_F4        5

// implemented bits of each status group
`define ASM_G1_VALID 8'h75
`define ASM_G2_VALID 8'hfe

// reset values
`define ASM_RST_REG  8'h00
`define ASM_RST_FAN  3'h0

`endif

// ---- hw/asm_pkg.sv ----
package asm_pkg;

  // whole state of the alert block
  typedef struct packed {
    logic [7:0] st1;
    logic [7:0] st2;
    logic [7:0] mask1;
    logic [7:0] mask2;
    logic [7:0] cfg3;
    logic [7:0] cfg4;
    logic [7:0] rdata;
    logic       alert;
    logic       timing;
    logic [2:0] full_speed_on_overheat;
  } asm_state_t;

endpackage : asm_pkg

// ---- verif/asm_alert_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "asm_params.svh"

module asm_alert_tb;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic [7:0] c1 = 8'h00;
  logic [7:0] g2 = 8'h00;
  logic       hot = 1'b0;
  logic       line = 1'b1;
  logic       drv = 1'b0;
  logic [2:0] run = 3'h0;
  logic [7:0] addr, wdata, rdata, rv;
  logic       wr, rd, al_n, ln_o, ln_oe, tmg, s_o, s_oe, m_o, m_oe;
  logic [2:0] fs;
  int         n_mismatch = 0;
  int         total_checks = 0;

  // 200 MHz clock
  always #2.5 clk = ~clk;

  asm_host host (.i_clk_sys(clk), .o_addr(addr), .o_wr(wr), .o_rd(rd),
    .o_wdata(wdata), .i_rdata(rdata));

  asm_alert dut (.i_clk_sys(clk), .i_srst(srst), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_grp1_cond(c1), .i_diode_two_fault(g2[7]), .i_diode_one_fault(g2[6]),
    .i_cooler_four_slow(g2[5]), .i_cooler_three_slow(g2[4]),
    .i_cooler_two_slow(g2[3]), .i_cooler_one_slow(g2[2]),
    .i_critical_temp(g2[1]), .i_hot_timer_over(hot),
    .i_overheat_line(line), .i_overheat_drive_req(drv),
    .o_overheat_line(ln_o), .o_overheat_line_oe(ln_oe),
    .o_overheat_timing(tmg), .i_fan_running(run), .o_full_speed(fs),
    .o_alert_n(al_n), .o_supply_pin_alert_o(s_o),
    .o_supply_pin_alert_oe(s_oe), .o_mp_pin_alert_o(m_o),
    .o_mp_pin_alert_oe(m_oe));

  // compare and count
  task automatic chk(input string nm, input logic [7:0] s,
                     input logic [7:0] e);
    total_checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    host.rd_reg(a, rv);
    chk("rdata", rv, e);
  endtask : rdchk

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step

  // verdict
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  task automatic t_reset();
    chk("alert pins", {5'h0, al_n, s_oe, m_oe}, 8'h04);
    rdchk(`ASM_OFS_CFG3, 8'h00);
    rdchk(`ASM_OFS_CFG4, 8'h00);
  endtask : t_reset

  // each group two source sets its own bit and sticks until gone and read
  task automatic t_sticky();
    for (int i = 1; i < 8; i++)
    begin
      g2 = 8'h01 << i;
      rdchk(`ASM_OFS_STATUS2, 8'h01 << i);
      rdchk(`ASM_OFS_STATUS1, 8'h80);
      g2 = 8'h00;
      rdchk(`ASM_OFS_STATUS2, 8'h01 << i);
      rdchk(`ASM_OFS_STATUS2, 8'h00);
    end
  endtask : t_sticky

  // bit 5 follows the timer limit once the overheat line is enabled
  task automatic t_timer();
    hot = 1'b1;
    rdchk(`ASM_OFS_STATUS2, 8'h00);
    host.wr_reg(`ASM_OFS_CFG3, 8'h02);
    rdchk(`ASM_OFS_STATUS2, 8'h20);
    host.wr_reg(`ASM_OFS_MASK2, 8'h20);
    chk("alert masked", {7'h0, al_n}, 8'h01);
    hot = 1'b0;
    rdchk(`ASM_OFS_STATUS2, 8'h20);
    host.wr_reg(`ASM_OFS_MASK2, 8'h00);
    host.wr_reg(`ASM_OFS_CFG3, 8'h00);
  endtask : t_timer

  // alert level, masking and release after the read
  task automatic t_alert();
    host.wr_reg(`ASM_OFS_CFG4, 8'h01);
    g2 = 8'h80;
    step(2);
    chk("alert", {6'h0, al_n, s_oe}, 8'h01);
    g2 = 8'h00;
    step(2);
    chk("alert held", {7'h0, al_n}, 8'h00);
    host.wr_reg(`ASM_OFS_MASK1, 8'h80);
    step(1);
    chk("alert mask one", {7'h0, al_n}, 8'h01);
    host.wr_reg(`ASM_OFS_MASK1, 8'h00);
    host.wr_reg(`ASM_OFS_MASK2, 8'h80);
    step(1);
    chk("alert mask two", {7'h0, al_n}, 8'h01);
    rdchk(`ASM_OFS_STATUS2, 8'h80);
    host.wr_reg(`ASM_OFS_MASK2, 8'h00);
    step(1);
    chk("alert released", {7'h0, al_n}, 8'h01);
    host.wr_reg(`ASM_OFS_MASK1, 8'h40);
    c1 = 8'h40;
    step(2);
    chk("alert group one", {7'h0, al_n}, 8'h01);
    c1 = 8'h00;
    rdchk(`ASM_OFS_STATUS1, 8'h40);
    host.wr_reg(`ASM_OFS_MASK1, 8'h00);
  endtask : t_alert

  // overheat line input, full_speed_on_overheat of running fans, second alert pin
  task automatic t_full_speed_on_overheat();
    host.wr_reg(`ASM_OFS_CFG3, 8'h07);
    run = 3'b101;
    line = 1'b0;
    step(2);
    chk("full_speed_on_overheat", {4'h0, tmg, fs}, 8'h0d);
    drv = 1'b1;
    g2 = 8'h02;
    step(2);
    chk("pins", {6'h0, ln_oe, m_oe}, 8'h03);
    chk("pin levels", {5'h0, ln_o, s_o, m_o}, 8'h00);
    line = 1'b1;
    drv = 1'b0;
    step(2);
    chk("full_speed_on_overheat off", {4'h0, tmg, fs}, 8'h00);
  endtask : t_full_speed_on_overheat

  // reset in mid-run with a source still out of limit
  task automatic t_rerst();
    srst = 1'b1;
    step(2);
    srst = 1'b0;
    step(1);
    chk("pins after reset", {6'h0, s_oe, m_oe}, 8'h00);
    chk("alert after reset", {7'h0, al_n}, 8'h00);
    rdchk(`ASM_OFS_CFG3, 8'h00);
    g2 = 8'h00;
    rdchk(`ASM_OFS_STATUS2, 8'h02);
  endtask : t_rerst

  // watchdog
  initial
  begin
    #100us;
    n_mismatch++;
    complete_run();
  end

  // main sequence
  initial
  begin
    step(16);
    srst = 1'b0;
    step(1);
    t_reset();
    t_sticky();
    t_timer();
    t_alert();
    t_full_speed_on_overheat();
    t_rerst();
    complete_run();
  end
endmodule : asm_alert_tb

`default_nettype wire

// ---- verif/asm_host.sv ----
`timescale 1ns/1ps
`default_nettype none

module asm_host (
  // clock
  input  wire logic       i_clk_sys,
  // register port toward the block
  output var  logic [7:0] o_addr,
  output var  logic       o_wr,
  output var  logic       o_rd,
  output var  logic [7:0] o_wdata,
  input  wire logic [7:0] i_rdata
);
  // idle bus at time zero
  initial
  begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'h00;
  end

  // one write strobe, raised and dropped on falling edges
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk_sys);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_clk_sys);
    o_wr = 1'b0;
    o_wdata = ~d; // released data is not left showing
  endtask : wr_reg

  // one read strobe, data taken once the registered answer settles
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clk_sys);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_clk_sys);
    o_rd = 1'b0;
    d = i_rdata;
  endtask : rd_reg
endmodule : asm_host

`default_nettype wire
